// [design/srcs_top.sv]
/*
  S/PDIF input selection, biphase decoding, status extraction and master clock select.
  Assumes the link clock samples each biphase half-cell once and that an
  external clock gate follows the two select outputs.
*/
module srcs_top (
  // Clocks and reset
  input wire logic clk_in,
  input wire logic link_clk_in,
  input wire logic rstn_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Digital audio pins
  input wire logic [7:0] spdif_inputs_in,
  output logic passthrough_output_pin_out,
  // Clock control
  input wire logic pll_lock_in,
  output logic mclk_sel_pll_out,
  output logic mclk_sel_ext_out,
  output logic pll_frame_clock_ref_sel_out,
  output logic force_lock_bit_out,
  output logic [1:0] ext_ratio_out,
  // Decoded stream
  input wire logic q_int_unmask_in,
  output logic [23:0] sample_out,
  output logic sample_chan_b_out,
  output logic sample_valid_out,
  output logic non_audio_out,
  output logic q_int_out
);
  function automatic logic is_pre(input logic [7:0] sh, input logic [7:0] pat);
    is_pre = (sh == pat) || (sh == ~pat);
  endfunction

  function automatic logic is_q(input logic [7:0] addr);
    is_q = (addr >= srcs_pkg::ADDR_Q_FIRST) && (addr <= srcs_pkg::ADDR_Q_LAST);
  endfunction

  // ****************************************************************
  // Link domain: reset, pin synchronisers and input selection
  // ****************************************************************
  logic [1:0] lrst;
  logic lrstn;
  logic [7:0] din_q1, din_q2, mux_q1, mux_q2, mux_q3, mux_use;
  logic [7:0] sh;
  logic bit_in;
  logic [7:0] mux_ctrl;

  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) lrst <= 2'h0;
    else lrst <= {lrst[0], 1'b1};
  end
  assign lrstn = lrst[1];

  always_ff @(posedge link_clk_in or negedge lrstn) begin
    if (!lrstn) begin
      din_q1 <= 8'h00;
      din_q2 <= 8'h00;
      mux_q1 <= srcs_pkg::MUX_CTRL_RST;
      mux_q2 <= srcs_pkg::MUX_CTRL_RST;
      mux_q3 <= srcs_pkg::MUX_CTRL_RST;
      mux_use <= srcs_pkg::MUX_CTRL_RST;
    end else begin
      din_q1 <= spdif_inputs_in;
      din_q2 <= din_q1;
      mux_q1 <= mux_ctrl;
      mux_q2 <= mux_q1;
      mux_q3 <= mux_q2;
      if (mux_q2 == mux_q3) mux_use <= mux_q3;
    end
  end

  assign bit_in = din_q2[mux_use[srcs_pkg::MUX_RX_LSB +: 3]];

  always_ff @(posedge link_clk_in or negedge lrstn) begin
    if (!lrstn) begin
      passthrough_output_pin_out <= 1'b0;
      sh <= 8'h00;
    end else begin
      passthrough_output_pin_out <= din_q2[mux_use[srcs_pkg::MUX_TX_LSB +: 3]];
      sh <= {sh[6:0], bit_in};
    end
  end

  // ****************************************************************
  // Link domain: biphase decoder
  // ****************************************************************
  logic [5:0] cnt;
  logic locked, chan_b, par, bip, tog, cell_bit;
  logic [7:0] fr;
  logic [23:0] aud;
  logic val;
  logic [15:0] cs_acc, cs_hold;
  logic [79:0] q_acc, q_hold;
  logic [4:0] slot;
  logic hit, data_cyc;
  srcs_pkg::srcs_sub_s sub_hold;

  assign hit = is_pre(sh, srcs_pkg::PRE_B) | is_pre(sh, srcs_pkg::PRE_M)
               | is_pre(sh, srcs_pkg::PRE_W);
  assign slot = cnt[5:1];
  assign cell_bit = sh[1] ^ sh[0];
  assign data_cyc = locked && cnt[0] && (slot < 5'd28);

  always_ff @(posedge link_clk_in or negedge lrstn) begin
    if (!lrstn) begin
      cnt <= 6'h00;
      locked <= 1'b0;
      chan_b <= 1'b0;
      fr <= 8'h00;
    end else if (hit && (!locked || cnt >= 6'd55)) begin
      cnt <= 6'h00;
      locked <= 1'b1;
      chan_b <= is_pre(sh, srcs_pkg::PRE_W);
      if (is_pre(sh, srcs_pkg::PRE_B)) fr <= 8'h00;
      else if (is_pre(sh, srcs_pkg::PRE_M)) fr <= fr + 8'h01;
    end else begin
      cnt <= cnt + 6'h01;
      if (cnt == 6'd63) locked <= 1'b0;
    end
  end

  always_ff @(posedge link_clk_in or negedge lrstn) begin
    if (!lrstn) begin
      par <= 1'b0;
      bip <= 1'b0;
      val <= 1'b0;
      aud <= 24'h00_0000;
      cs_acc <= 16'h0000;
      q_acc <= '0;
    end else if (hit && (!locked || cnt >= 6'd55)) begin
      par <= 1'b0;
      bip <= 1'b0;
    end else if (data_cyc) begin
      par <= par ^ cell_bit;
      if (sh[2] == sh[1]) bip <= 1'b1;
      if (slot < 5'd24) aud[slot] <= cell_bit;
      if (slot == 5'd24) val <= cell_bit;
      if (slot == 5'd25 && !chan_b && fr < 8'(srcs_pkg::Q_BITS)) begin
        q_acc[fr[6:0]] <= cell_bit;
      end
      if (slot == 5'd26 && !chan_b && fr < 8'(srcs_pkg::CS_FRAMES)) begin
        cs_acc[fr[3:0]] <= cell_bit;
      end
    end
  end

  always_ff @(posedge link_clk_in or negedge lrstn) begin
    if (!lrstn) begin
      tog <= 1'b0;
      sub_hold <= '0;
      cs_hold <= 16'h0000;
      q_hold <= '0;
    end else if (data_cyc && slot == 5'd27) begin
      tog <= ~tog;
      sub_hold.audio <= aud;
      sub_hold.chan_b <= chan_b;
      sub_hold.par_err <= par ^ cell_bit;
      sub_hold.bip_err <= bip || (sh[2] == sh[1]);
      sub_hold.val_err <= val;
      sub_hold.new_q <= !chan_b && fr == 8'(srcs_pkg::Q_BITS - 1);
      if (!chan_b && fr == 8'(srcs_pkg::CS_FRAMES - 1)) cs_hold <= cs_acc;
      if (!chan_b && fr == 8'(srcs_pkg::Q_BITS - 1)) q_hold <= q_acc;
    end
  end

  // ****************************************************************
  // System domain: crossings
  // ****************************************************************
  logic [2:0] tog_s;
  logic [1:0] lock_s, lk_s;
  logic ev;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tog_s <= 3'h0;
      lock_s <= 2'h0;
      lk_s <= 2'h0;
    end else begin
      tog_s <= {tog_s[1:0], tog};
      lock_s <= {lock_s[0], pll_lock_in};
      lk_s <= {lk_s[0], locked};
    end
  end
  assign ev = tog_s[1] ^ tog_s[2];

  // ****************************************************************
  // System domain: registers
  // ****************************************************************
  logic [7:0] clk_ctrl, cs_reg, err_reg;
  logic [7:0] q_reg [srcs_pkg::Q_BYTES];
  logic [7:0] err_set;
  logic wr_clk, rd_err, rd_q0;

  assign wr_clk = reg_wr_in && reg_addr_in == srcs_pkg::ADDR_CLK_CTRL;
  assign rd_err = reg_rd_in && reg_addr_in == srcs_pkg::ADDR_RX_ERR;
  assign rd_q0 = reg_rd_in && reg_addr_in == srcs_pkg::ADDR_Q_FIRST;
  assign err_set = {4'h0, !lk_s[1], ev && sub_hold.val_err, ev && sub_hold.bip_err,
                    ev && sub_hold.par_err};

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clk_ctrl <= srcs_pkg::CLK_CTRL_RST;
      mux_ctrl <= srcs_pkg::MUX_CTRL_RST;
    end else if (reg_wr_in) begin
      if (wr_clk) begin
        clk_ctrl[7:4] <= reg_wdata_in[7:4];
        clk_ctrl[1:0] <= reg_wdata_in[1:0];
        if (reg_wdata_in[3:2] != srcs_pkg::RATIO_RESERVED) begin
          clk_ctrl[3:2] <= reg_wdata_in[3:2];
        end
      end
      if (reg_addr_in == srcs_pkg::ADDR_MUX_CTRL) mux_ctrl <= reg_wdata_in & 8'h77;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) err_reg <= 8'h00;
    else err_reg <= (rd_err ? 8'h00 : err_reg) | err_set;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) q_int_out <= 1'b0;
    else q_int_out <= (q_int_out && !rd_q0) || (ev && sub_hold.new_q && q_int_unmask_in);
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cs_reg <= 8'h00;
      non_audio_out <= 1'b0;
      sample_out <= 24'h00_0000;
      sample_chan_b_out <= 1'b0;
      sample_valid_out <= 1'b0;
    end else begin
      sample_valid_out <= ev;
      if (ev) begin
        sample_out <= sub_hold.audio;
        sample_chan_b_out <= sub_hold.chan_b;
        cs_reg <= {cs_hold[11:8], cs_hold[3:0]};
        non_audio_out <= cs_hold[1];
      end
    end
  end

  for (genvar g = 0; g < srcs_pkg::Q_BYTES; g++) begin : g_q
    always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) q_reg[g] <= 8'h00;
      else if (ev && sub_hold.new_q) q_reg[g] <= q_hold[8 * g +: 8];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      if (reg_addr_in == srcs_pkg::ADDR_CLK_CTRL) reg_rdata_out <= clk_ctrl;
      else if (reg_addr_in == srcs_pkg::ADDR_MUX_CTRL) reg_rdata_out <= mux_ctrl;
      else if (reg_addr_in == srcs_pkg::ADDR_RX_CS) reg_rdata_out <= cs_reg;
      else if (reg_addr_in == srcs_pkg::ADDR_RX_ERR) reg_rdata_out <= err_reg;
      else if (is_q(reg_addr_in)) reg_rdata_out <= q_reg[4'(reg_addr_in - srcs_pkg::ADDR_Q_FIRST)];
      else reg_rdata_out <= 8'h00;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pll_frame_clock_ref_sel_out <= 1'b0;
      force_lock_bit_out <= 1'b0;
      ext_ratio_out <= 2'h0;
    end else begin
      pll_frame_clock_ref_sel_out <= clk_ctrl[srcs_pkg::CLK_FRAME_REF_BIT];
      force_lock_bit_out <= clk_ctrl[srcs_pkg::CLK_FORCE_BIT];
      ext_ratio_out <= clk_ctrl[srcs_pkg::CLK_RATIO_LSB +: 2];
    end
  end

  // ****************************************************************
  // System domain: glitch-free master clock selection
  // ****************************************************************
  srcs_pkg::srcs_sw_e sw_state;
  logic [2:0] gap;
  logic [1:0] sw_mode;
  logic want_ext;

  assign sw_mode = clk_ctrl[srcs_pkg::CLK_SW_LSB +: 2];
  always_comb begin
    if (sw_mode == srcs_pkg::SW_MAN_PLL) want_ext = 1'b0;
    else if (sw_mode == srcs_pkg::SW_MAN_EXT) want_ext = 1'b1;
    else want_ext = !lock_s[1];
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sw_state <= srcs_pkg::SW_RUN_PLL;
      gap <= 3'h0;
      mclk_sel_pll_out <= 1'b1;
      mclk_sel_ext_out <= 1'b0;
    end else begin
      unique case (sw_state)
        srcs_pkg::SW_RUN_PLL: begin
          gap <= 3'h0;
          if (want_ext) begin
            sw_state <= srcs_pkg::SW_GAP_EXT;
            mclk_sel_pll_out <= 1'b0;
          end
        end
        srcs_pkg::SW_GAP_EXT: begin
          gap <= gap + 3'h1;
          if (gap == 3'(srcs_pkg::SW_GAP_CYC - 1)) begin
            sw_state <= srcs_pkg::SW_RUN_EXT;
            mclk_sel_ext_out <= 1'b1;
          end
        end
        srcs_pkg::SW_RUN_EXT: begin
          gap <= 3'h0;
          if (!want_ext) begin
            sw_state <= srcs_pkg::SW_GAP_PLL;
            mclk_sel_ext_out <= 1'b0;
          end
        end
        srcs_pkg::SW_GAP_PLL: begin
          gap <= gap + 3'h1;
          if (gap == 3'(srcs_pkg::SW_GAP_CYC - 1)) begin
            sw_state <= srcs_pkg::SW_RUN_PLL;
            mclk_sel_pll_out <= 1'b1;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_quiet;
    !mclk_sel_ext_out && !mclk_sel_pll_out;
  endsequence
  property p_gap;
    @(posedge clk_in) disable iff (!rstn_in)
      $fell(mclk_sel_pll_out) |-> s_quiet [*4];
  endproperty
  a_gap: assert property (p_gap) else $error("clock switch gap too short");
  property p_auto;
    @(posedge clk_in) disable iff (!rstn_in)
      (sw_mode == 2'h2 && mclk_sel_pll_out && !lock_s[1]) |-> ##[1:8] mclk_sel_ext_out;
  endproperty
  a_auto: assert property (p_auto) else $error("no switch on lock loss");
  property p_manual;
    @(posedge clk_in) disable iff (!rstn_in)
      (sw_mode == srcs_pkg::SW_MAN_PLL && mclk_sel_pll_out && !reg_wr_in) |=> mclk_sel_pll_out;
  endproperty
  a_manual: assert property (p_manual) else $error("manual source changed");
  property p_frame_ref;
    @(posedge clk_in) disable iff (!rstn_in)
      wr_clk |-> ##2 pll_frame_clock_ref_sel_out == $past(reg_wdata_in[5], 2);
  endproperty
  a_frame_ref: assert property (p_frame_ref) else $error("frame ref select wrong");
  property p_err_hold;
    @(posedge clk_in) disable iff (!rstn_in)
      (err_reg != 8'h00 && !rd_err) |=> (err_reg & $past(err_reg)) == $past(err_reg);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag lost");
  property p_q_int;
    @(posedge clk_in) disable iff (!rstn_in)
      (ev && sub_hold.new_q && q_int_unmask_in) |=> q_int_out && q_reg[0] == q_hold[7:0];
  endproperty
  a_q_int: assert property (p_q_int) else $error("q block not signalled");
  property p_non_audio;
    @(posedge clk_in) disable iff (!rstn_in)
      ev |=> non_audio_out == cs_reg[1] && sample_valid_out;
  endproperty
  a_non_audio: assert property (p_non_audio) else $error("non-audio flag wrong");
  property p_pass;
    @(posedge link_clk_in) disable iff (!lrstn)
      ##1 passthrough_output_pin_out == $past(din_q2[mux_use[6:4]]);
  endproperty
  a_pass: assert property (p_pass) else $error("pass-through mismatch");
endmodule

// [dv/srcs_spdif_src.sv]
/*
  Behavioural S/PDIF source that feeds the primary input of the receiver.
  Assumes one biphase half-cell per link clock, launched on the falling edge.
*/
module srcs_spdif_src (
  // Link side
  input wire logic link_clk_in,
  input wire logic enable_in,
  input wire logic [23:0] audio_in,
  input wire logic non_audio_in,
  // Line
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] shreg = 64'h0;
  logic [63:0] v;
  logic [27:0] d;
  logic [7:0] pre;
  logic [5:0] pos = 6'h0;
  logic [7:0] frame = 8'h0;
  logic chan_b = 1'b0;
  logic cs;
  logic u;
  initial line_out = 1'b0;
  // ****************************************************************
  // Subframe builder
  // ****************************************************************
  function automatic logic [63:0] make_sub(input logic [7:0] p, input logic [27:0] dat,
                                           input logic lvl);
    logic [63:0] r;
    logic l;
    r = 64'h0;
    r[63:56] = lvl ? ~p : p;
    l = r[56];
    for (int i = 0; i < 28; i++) begin
      l = ~l;
      r[55 - 2 * i] = l;
      l = l ^ dat[i];
      r[54 - 2 * i] = l;
    end
    return r;
  endfunction
  // ****************************************************************
  // Transmitter
  // ****************************************************************
  always @(negedge link_clk_in) begin
    if (!enable_in) begin
      line_out <= ~line_out;
      pos <= 6'h0;
    end else if (pos == 6'h0) begin
      cs = !chan_b && frame == 8'h01 && non_audio_in;
      u = !chan_b && frame < 8'h50 && (frame[0] || frame == 8'h48);
      pre = chan_b ? srcs_pkg::PRE_W : (frame == 8'h00 ? srcs_pkg::PRE_B : srcs_pkg::PRE_M);
      d = {^{cs, u, audio_in}, cs, u, 1'b0, audio_in};
      v = make_sub(pre, d, line_out);
      line_out <= v[63];
      shreg <= v << 1;
      pos <= 6'h1;
    end else begin
      line_out <= shreg[63];
      shreg <= shreg << 1;
      pos <= pos + 6'h1;
      if (pos == 6'h3F) begin
        chan_b <= ~chan_b;
        if (chan_b) begin
          frame <= (frame == 8'hBF) ? 8'h00 : frame + 8'h01;
        end
      end
    end
  end
endmodule

// [dv/srcs_top_tb.sv]
/*
  Self-checking bench for the receiver and master clock select block.
  Assumes the S/PDIF source model on input 0 and the bench driving the rest.
*/
module srcs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [23:0] AUDIO = 24'h5A_C3E1;
  logic clk_in = 1'b0;
  logic link_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] pins = 8'h00;
  logic pll_lock_in = 1'b1;
  logic q_int_unmask_in = 1'b0;
  logic src_en = 1'b0;
  logic src_line;
  wire logic [7:0] spdif_inputs_in = {pins[7:1], src_line};
  logic [7:0] reg_rdata_out;
  logic passthrough_output_pin_out, mclk_sel_pll_out, mclk_sel_ext_out;
  logic pll_frame_clock_ref_sel_out, force_lock_bit_out, sample_chan_b_out;
  logic sample_valid_out, non_audio_out, q_int_out;
  logic [1:0] ext_ratio_out;
  logic [23:0] sample_out;
  int error_cnt = 0;
  int n_checks = 0;
  always #50 clk_in = ~clk_in;
  initial begin
    #13;
    forever #40 link_clk_in = ~link_clk_in;
  end
  srcs_spdif_src srcs_spdif_src_i (.link_clk_in(link_clk_in), .enable_in(src_en),
    .audio_in(AUDIO), .non_audio_in(1'b1), .line_out(src_line));
  srcs_top srcs_top_i (.clk_in(clk_in), .link_clk_in(link_clk_in), .rstn_in(rstn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .spdif_inputs_in(spdif_inputs_in),
    .passthrough_output_pin_out(passthrough_output_pin_out), .pll_lock_in(pll_lock_in),
    .mclk_sel_pll_out(mclk_sel_pll_out), .mclk_sel_ext_out(mclk_sel_ext_out),
    .pll_frame_clock_ref_sel_out(pll_frame_clock_ref_sel_out),
    .force_lock_bit_out(force_lock_bit_out), .ext_ratio_out(ext_ratio_out),
    .q_int_unmask_in(q_int_unmask_in), .sample_out(sample_out),
    .sample_chan_b_out(sample_chan_b_out), .sample_valid_out(sample_valid_out),
    .non_audio_out(non_audio_out), .q_int_out(q_int_out));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic close_out();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk_v(input string nm, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic poll_end(input string nm, input logic ok);
    chk_v(nm, 24'h00_0001, {23'h0, ok});
    if (ok !== 1'b1) begin
      close_out();
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] dat);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= dat;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] msk);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    chk_v($sformatf("reg_%h", a), {16'h0, exp & msk}, {16'h0, reg_rdata_out & msk});
  endtask
  task automatic sw_wait(input logic ext, input int gap_exp);
    int both;
    int gap;
    both = 0;
    gap = 0;
    for (int n = 0; n < 30; n++) begin
      @(negedge clk_in);
      both += int'(mclk_sel_pll_out & mclk_sel_ext_out);
      gap += int'(!mclk_sel_pll_out & !mclk_sel_ext_out);
    end
    chk_v("both_sel", 24'h00_0000, 24'(both));
    chk_v("gap", 24'(gap_exp), 24'(gap));
    chk_v("ext_sel", {23'h0, ext}, {23'h0, mclk_sel_ext_out});
    @(posedge clk_in);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    chk_v("pll_sel", 24'h00_0001, {23'h0, mclk_sel_pll_out});
    rd_chk(8'h24, srcs_pkg::MUX_CTRL_RST, 8'hFF);
    rd_chk(8'h06, srcs_pkg::CLK_CTRL_RST, 8'hFF);
    rd_chk(8'h07, 8'h00, 8'hFF);
  endtask
  task automatic t_mux();
    for (int k = 1; k < 8; k++) begin
      wr_reg(8'h24, 8'(k << 4));
      rd_chk(8'h24, 8'(k << 4), 8'hFF);
      for (int p = 0; p < 2; p++) begin
        @(posedge clk_in);
        pins <= (p == 1) ? ~(8'h01 << k) : (8'h01 << k);
        repeat (8) @(posedge link_clk_in);
        @(negedge clk_in);
        chk_v("passthrough", 24'(1 - p), {23'h0, passthrough_output_pin_out});
      end
    end
  endtask
  task automatic t_clk();
    wr_reg(8'h06, 8'h01);
    sw_wait(1'b1, srcs_pkg::SW_GAP_CYC);
    pll_lock_in <= 1'b0;
    sw_wait(1'b1, 0);
    wr_reg(8'h06, 8'h00);
    sw_wait(1'b0, srcs_pkg::SW_GAP_CYC);
    wr_reg(8'h06, 8'h02);
    sw_wait(1'b1, srcs_pkg::SW_GAP_CYC);
    pll_lock_in <= 1'b1;
    sw_wait(1'b0, srcs_pkg::SW_GAP_CYC);
    pll_lock_in <= 1'b0;
    sw_wait(1'b1, srcs_pkg::SW_GAP_CYC);
    pll_lock_in <= 1'b1;
    wr_reg(8'h06, 8'h28);
    sw_wait(1'b0, srcs_pkg::SW_GAP_CYC);
    chk_v("frame_ref", 24'h00_0001, {23'h0, pll_frame_clock_ref_sel_out});
    wr_reg(8'h06, 8'h3C);
    rd_chk(8'h06, 8'h38, 8'hFF);
    chk_v("ratio", 24'h00_0002, {22'h0, ext_ratio_out});
    chk_v("force", 24'h00_0001, {23'h0, force_lock_bit_out});
  endtask
  task automatic t_stream();
    int cnt;
    int n;
    int nb;
    wr_reg(8'h24, 8'h00);
    src_en <= 1'b1;
    cnt = 0;
    nb = 0;
    for (n = 0; n < 4000 && cnt < 3; n++) begin
      @(negedge clk_in);
      cnt += int'(sample_valid_out === 1'b1);
      nb += int'(sample_valid_out === 1'b1 && sample_chan_b_out === 1'b1);
    end
    poll_end("sample_valid", cnt == 3);
    chk_v("chan_b", 24'h00_0001, 24'(nb));
    chk_v("sample", AUDIO, sample_out);
    for (n = 0; n < 45000 && non_audio_out !== 1'b1; n++) @(negedge clk_in);
    poll_end("non_audio", non_audio_out);
    rd_chk(8'h25, 8'h02, 8'hFF);
    @(posedge clk_in);
    q_int_unmask_in <= 1'b1;
    for (n = 0; n < 45000 && q_int_out !== 1'b1; n++) @(negedge clk_in);
    poll_end("q_int", q_int_out);
    rd_chk(8'h39, 8'hAB, 8'hFF);
    rd_chk(8'h30, 8'hAA, 8'hFF);
    @(negedge clk_in);
    chk_v("q_int_clr", 24'h00_0000, {23'h0, q_int_out});
    rd_chk(8'h26, 8'h00, 8'h00);
    rd_chk(8'h26, 8'h00, 8'hFF);
    @(posedge clk_in);
    src_en <= 1'b0;
    repeat (200) @(posedge clk_in);
    rd_chk(8'h26, 8'h08, 8'h08);
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(negedge clk_in);
    t_reset();
    t_mux();
    t_clk();
    t_stream();
    close_out();
  end
endmodule

// [include/srcs_pkg.sv]
/*
  Shared constants and types of the S/PDIF receiver and clock select block.
  Assumes a 10 MHz system clock and a link clock at twice the biphase bit rate.
*/
package srcs_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CLK_CTRL = 8'h06;
  localparam logic [7:0] ADDR_MUX_CTRL = 8'h24;
  localparam logic [7:0] ADDR_RX_CS = 8'h25;
  localparam logic [7:0] ADDR_RX_ERR = 8'h26;
  localparam logic [7:0] ADDR_Q_FIRST = 8'h30;
  localparam logic [7:0] ADDR_Q_LAST = 8'h39;
  localparam logic [7:0] CLK_CTRL_RST = 8'h00;
  localparam logic [7:0] MUX_CTRL_RST = 8'h00;
  localparam int CLK_SW_LSB = 0;
  localparam int CLK_RATIO_LSB = 2;
  localparam int CLK_FORCE_BIT = 4;
  localparam int CLK_FRAME_REF_BIT = 5;
  localparam int MUX_RX_LSB = 0;
  localparam int MUX_TX_LSB = 4;
  localparam int ERR_PAR = 0;
  localparam int ERR_BIP = 1;
  localparam int ERR_VAL = 2;
  localparam int ERR_UNLOCK = 3;
  localparam logic [1:0] SW_MAN_PLL = 2'h0;
  localparam logic [1:0] SW_MAN_EXT = 2'h1;
  localparam logic [1:0] RATIO_RESERVED = 2'h3;
  // ****************************************************************
  // Timing and stream figures
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int SW_GAP_NS = 400;
  localparam int SW_GAP_CYC = (SW_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_FRAMES = 16;
  localparam int Q_BITS = 80;
  localparam int Q_BYTES = 10;
  localparam int PLL_RATIO = 256;
  localparam int MIX_PAIRS = 3;
  localparam int SSM_MAX_KHZ = 50;
  localparam int DSM_MAX_KHZ = 100;
  localparam int QSM_MAX_KHZ = 192;
  localparam logic [7:0] PRE_B = 8'hE8;
  localparam logic [7:0] PRE_M = 8'hE2;
  localparam logic [7:0] PRE_W = 8'hE4;
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {SW_RUN_PLL, SW_GAP_EXT, SW_RUN_EXT, SW_GAP_PLL} srcs_sw_e;
  typedef struct packed {
    logic [23:0] audio;
    logic chan_b;
    logic par_err;
    logic bip_err;
    logic val_err;
    logic new_q;
  } srcs_sub_s;
endpackage
